// ==== core/opc_plane_color_control.sv ====
`timescale 1ns/1ps
`include "opc_params.svh"
module opc_plane_color_control #(
	parameter int LIMIT_WIDTH = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic horizontal_sync_in,
	input wire logic vertical_sync_in,
	input wire opc_pkg::opc_pixel_type pixel_in,
	output logic [2:0] palette_index,
	output logic osd_active,
	output logic blank_out,
	output logic ipin_out,
	output logic ipin_enable,
	output logic luma_blank_pin_select
);
	////////////////////////////////////////////////////////////////
	logic [7:0] display_control_reg;
	logic [7:0] char_attribute_reg;
	logic [7:0] raster_background_control_reg;
	logic [7:0] border_background_color_reg;
	logic [LIMIT_WIDTH-1:0] window_upper_limit_reg;
	logic [LIMIT_WIDTH-1:0] window_lower_limit_reg;
	logic [7:0] area_plane_color_reg;
	logic [7:0] port_select_register_reg;
	logic wr_en;
	logic rd_hit;
	assign wr_en = psel & penable & pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			`OPC_ADDR_DISPLAY_CONTROL,
			`OPC_ADDR_CHAR_ATTRIBUTE,
			`OPC_ADDR_RASTER_BG_CONTROL,
			`OPC_ADDR_BORDER_BG_COLOR,
			`OPC_ADDR_WINDOW_UPPER,
			`OPC_ADDR_WINDOW_LOWER,
			`OPC_ADDR_AREA_PLANE_COLOR,
			`OPC_ADDR_PORT_SELECT,
			`OPC_ADDR_STATUS: rd_hit = 1'b1;
			default: rd_hit = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~rd_hit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_control_reg <= `OPC_RESET_BYTE;
			char_attribute_reg <= `OPC_RESET_BYTE;
			raster_background_control_reg <= `OPC_RESET_BYTE;
			border_background_color_reg <= `OPC_RESET_BYTE;
			window_upper_limit_reg <= `OPC_RESET_WINDOW_UPPER;
			window_lower_limit_reg <= `OPC_RESET_WINDOW_LOWER;
			area_plane_color_reg <= `OPC_RESET_BYTE;
			port_select_register_reg <= `OPC_RESET_BYTE;
		end else if (wr_en) begin
			case (paddr)
				`OPC_ADDR_DISPLAY_CONTROL: display_control_reg <= pwdata[7:0];
				`OPC_ADDR_CHAR_ATTRIBUTE: char_attribute_reg <= pwdata[7:0];
				`OPC_ADDR_RASTER_BG_CONTROL: raster_background_control_reg <= pwdata[7:0];
				`OPC_ADDR_BORDER_BG_COLOR: border_background_color_reg <= pwdata[7:0];
				`OPC_ADDR_WINDOW_UPPER: window_upper_limit_reg <= pwdata[LIMIT_WIDTH-1:0];
				`OPC_ADDR_WINDOW_LOWER: window_lower_limit_reg <= pwdata[LIMIT_WIDTH-1:0];
				`OPC_ADDR_AREA_PLANE_COLOR: area_plane_color_reg <= pwdata[7:0];
				`OPC_ADDR_PORT_SELECT: port_select_register_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// sync inputs, three stages, change when 2nd and 3rd agree
	logic [2:0] hs_sync;
	logic [2:0] vs_sync;
	logic hs_level;
	logic vs_level;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_sync <= 3'h7;
			vs_sync <= 3'h7;
			hs_level <= 1'b1;
			vs_level <= 1'b1;
		end else begin
			hs_sync <= {hs_sync[1:0], horizontal_sync_in};
			vs_sync <= {vs_sync[1:0], vertical_sync_in};
			if (hs_sync[1] == hs_sync[2]) begin
				hs_level <= hs_sync[2];
			end
			if (vs_sync[1] == vs_sync[2]) begin
				vs_level <= vs_sync[2];
			end
		end
	end
	logic hs_fall;
	logic vs_fall;
	assign hs_fall = hs_level & (hs_sync[1] == hs_sync[2]) & ~hs_sync[2];
	assign vs_fall = vs_level & (vs_sync[1] == vs_sync[2]) & ~vs_sync[2];
	// line counter, in double scan every other sync line counts
	logic [LIMIT_WIDTH-1:0] line_count_reg;
	logic half_line_reg;
	logic double_scan;
	assign double_scan = display_control_reg[`OPC_BIT_DOUBLE_SCAN];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_count_reg <= '0;
			half_line_reg <= 1'b0;
		end else if (vs_fall) begin
			line_count_reg <= '0;
			half_line_reg <= 1'b0;
		end else if (hs_fall) begin
			if (!double_scan || half_line_reg) begin
				if (line_count_reg != '1) begin
					line_count_reg <= line_count_reg + 1'b1;
				end
				half_line_reg <= 1'b0;
			end else begin
				half_line_reg <= 1'b1;
			end
		end
	end
	// lower limit line itself is outside
	logic in_window;
	assign in_window = (line_count_reg >= window_upper_limit_reg)
		& (line_count_reg < window_lower_limit_reg);
	logic window_ok;
	assign window_ok = ~display_control_reg[`OPC_BIT_WINDOW_ENABLE] | in_window;
	////////////////////////////////////////////////////////////////
	logic screen_bg;
	logic char_bg;
	logic draw_bg;
	logic [2:0] bg_sel;
	logic display_on;
	opc_pkg::opc_colors_type colors;
	assign screen_bg = raster_background_control_reg[`OPC_BIT_SCREEN_BG_ENABLE];
	assign char_bg = char_attribute_reg[`OPC_BIT_CHAR_BG_ENABLE];
	assign draw_bg = screen_bg & char_bg;
	assign display_on = display_control_reg[`OPC_BIT_DISPLAY_ENABLE];
	always_comb begin
		bg_sel = border_background_color_reg[6:4];
		if (display_control_reg[`OPC_BIT_CHAR_BG_SELECT]) begin
			// red/green from slant/underline, blue forced low
			bg_sel = {char_attribute_reg[`OPC_BIT_SLANT],
				char_attribute_reg[`OPC_BIT_UNDERLINE], 1'b0};
		end
	end
	assign colors.bg_color = bg_sel;
	assign colors.raster_color = raster_background_control_reg[2:0];
	assign colors.plane1_color = area_plane_color_reg[2:0];
	assign colors.plane2_color = area_plane_color_reg[6:4];
	logic plane1_hit;
	logic plane2_hit;
	logic raster_on;
	logic visible;
	assign visible = display_on & window_ok;
	assign plane1_hit = visible & pixel_in.plane1_area
		& raster_background_control_reg[`OPC_BIT_PLANE1_ON];
	assign plane2_hit = visible & pixel_in.plane2_area
		& raster_background_control_reg[`OPC_BIT_PLANE2_ON];
	assign raster_on = display_on & raster_background_control_reg[`OPC_BIT_FULL_RASTER];
	opc_pkg::opc_src_type src;
	always_comb begin
		if (visible && pixel_in.char_pixel) begin
			src = opc_pkg::OPC_SRC_CHAR;
		end else if (visible && pixel_in.char_area && draw_bg) begin
			src = opc_pkg::OPC_SRC_BG;
		end else if (visible && pixel_in.char_area && !char_bg) begin
			src = opc_pkg::OPC_SRC_VIDEO;
		end else if (plane1_hit) begin
			src = opc_pkg::OPC_SRC_PLANE1;
		end else if (plane2_hit) begin
			src = opc_pkg::OPC_SRC_PLANE2;
		end else if (raster_on) begin
			src = opc_pkg::OPC_SRC_RASTER;
		end else begin
			src = opc_pkg::OPC_SRC_VIDEO;
		end
	end
	logic [2:0] color_next;
	always_comb begin
		case (src)
			opc_pkg::OPC_SRC_CHAR: color_next = pixel_in.char_color;
			opc_pkg::OPC_SRC_BG: color_next = colors.bg_color;
			opc_pkg::OPC_SRC_PLANE1: color_next = colors.plane1_color;
			opc_pkg::OPC_SRC_PLANE2: color_next = colors.plane2_color;
			opc_pkg::OPC_SRC_RASTER: color_next = colors.raster_color;
			default: color_next = 3'h0;
		endcase
	end
	logic ipin_next;
	always_comb begin
		if (plane1_hit) begin
			ipin_next = area_plane_color_reg[`OPC_BIT_IPIN_PLANE1];
		end else if (plane2_hit) begin
			ipin_next = area_plane_color_reg[`OPC_BIT_IPIN_PLANE2];
		end else begin
			ipin_next = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			palette_index <= 3'h0;
			osd_active <= 1'b0;
			blank_out <= 1'b0;
			ipin_out <= 1'b0;
		end else begin
			palette_index <= color_next;
			osd_active <= (src != opc_pkg::OPC_SRC_VIDEO);
			blank_out <= (src != opc_pkg::OPC_SRC_VIDEO);
			ipin_out <= ipin_next;
		end
	end
	assign ipin_enable = ~port_select_register_reg[`OPC_BIT_IPIN_DISABLE];
	assign luma_blank_pin_select = port_select_register_reg[`OPC_BIT_LUMA_BLANK];
	////////////////////////////////////////////////////////////////
	always_comb begin
		prdata = 32'h0;
		case (paddr)
			`OPC_ADDR_DISPLAY_CONTROL: prdata[7:0] = display_control_reg;
			`OPC_ADDR_CHAR_ATTRIBUTE: prdata[7:0] = char_attribute_reg;
			`OPC_ADDR_RASTER_BG_CONTROL: prdata[7:0] = raster_background_control_reg;
			`OPC_ADDR_BORDER_BG_COLOR: prdata[7:0] = border_background_color_reg;
			`OPC_ADDR_WINDOW_UPPER: prdata[LIMIT_WIDTH-1:0] = window_upper_limit_reg;
			`OPC_ADDR_WINDOW_LOWER: prdata[LIMIT_WIDTH-1:0] = window_lower_limit_reg;
			`OPC_ADDR_AREA_PLANE_COLOR: prdata[7:0] = area_plane_color_reg;
			`OPC_ADDR_PORT_SELECT: prdata[7:0] = port_select_register_reg;
			`OPC_ADDR_STATUS: prdata[LIMIT_WIDTH+1:0] = {vs_level, in_window, line_count_reg};
			default: prdata = 32'h0;
		endcase
	end
	////////////////////////////////////////////////////////////////
	property p_bg_both;
		@(posedge pclk) disable iff (!presetn)
		(src == opc_pkg::OPC_SRC_BG) |-> (screen_bg && char_bg);
	endproperty
	a_bg_both: assert property (p_bg_both) else $error("bg without both enables");
	property p_bg_color;
		@(posedge pclk) disable iff (!presetn)
		(src == opc_pkg::OPC_SRC_BG) |=> (palette_index == $past(bg_sel));
	endproperty
	a_bg_color: assert property (p_bg_color) else $error("bg colour wrong");
	property p_even_bg;
		@(posedge pclk) disable iff (!presetn)
		display_control_reg[`OPC_BIT_CHAR_BG_SELECT] |-> (bg_sel[0] == 1'b0);
	endproperty
	a_even_bg: assert property (p_even_bg) else $error("odd palette in select mode");
	property p_display_off;
		@(posedge pclk) disable iff (!presetn)
		!display_on |=> !osd_active;
	endproperty
	a_display_off: assert property (p_display_off) else $error("output while disabled");
	property p_lower_line;
		@(posedge pclk) disable iff (!presetn)
		(display_control_reg[`OPC_BIT_WINDOW_ENABLE]
			&& line_count_reg == window_lower_limit_reg) |-> !visible;
	endproperty
	a_lower_line: assert property (p_lower_line) else $error("lower limit line shown");
	property p_priority;
		@(posedge pclk) disable iff (!presetn)
		(plane1_hit && plane2_hit && src != opc_pkg::OPC_SRC_CHAR
			&& src != opc_pkg::OPC_SRC_BG && src != opc_pkg::OPC_SRC_VIDEO)
			|=> (palette_index == $past(colors.plane1_color));
	endproperty
	a_priority: assert property (p_priority) else $error("plane 2 won overlap");
	property p_raster;
		@(posedge pclk) disable iff (!presetn)
		(src == opc_pkg::OPC_SRC_RASTER) |=> (blank_out && palette_index == $past(colors.raster_color));
	endproperty
	a_raster: assert property (p_raster) else $error("raster colour wrong");
	property p_ipin;
		@(posedge pclk) disable iff (!presetn)
		(!plane1_hit && !plane2_hit) |=> !ipin_out;
	endproperty
	a_ipin: assert property (p_ipin) else $error("i-pin outside planes");
	////////////////////////////////////////////////////////////////
	// layering seen at the registered outputs
	property p_char_top;
		@(posedge pclk) disable iff (!presetn)
		(visible && pixel_in.char_pixel)
			|=> (osd_active && palette_index == $past(pixel_in.char_color));
	endproperty
	a_char_top: assert property (p_char_top) else $error("character not on top");
	property p_char_bg_shown;
		@(posedge pclk) disable iff (!presetn)
		(visible && pixel_in.char_area && !pixel_in.char_pixel && draw_bg)
			|=> (osd_active && palette_index == $past(bg_sel));
	endproperty
	a_char_bg_shown: assert property (p_char_bg_shown) else $error("bg not drawn");
	property p_char_off_video;
		@(posedge pclk) disable iff (!presetn)
		(visible && pixel_in.char_area && !pixel_in.char_pixel && !char_bg) |=> !osd_active;
	endproperty
	a_char_off_video: assert property (p_char_off_video) else $error("char bg off shown");
	property p_transparent;
		@(posedge pclk) disable iff (!presetn)
		(visible && pixel_in.char_area && !pixel_in.char_pixel && !screen_bg && char_bg
			&& plane1_hit) |=> (palette_index == $past(colors.plane1_color));
	endproperty
	a_transparent: assert property (p_transparent) else $error("bg not transparent");
	property p_plane2_color;
		@(posedge pclk) disable iff (!presetn)
		(src == opc_pkg::OPC_SRC_PLANE2) |=> (palette_index == $past(colors.plane2_color));
	endproperty
	a_plane2_color: assert property (p_plane2_color) else $error("plane 2 colour wrong");
	property p_raster_only;
		@(posedge pclk) disable iff (!presetn)
		(raster_on && !visible)
			|=> (blank_out && palette_index == $past(colors.raster_color));
	endproperty
	a_raster_only: assert property (p_raster_only) else $error("raster not shown");
	property p_dark;
		@(posedge pclk) disable iff (!presetn)
		(!visible && !raster_on) |=> (!osd_active && !blank_out);
	endproperty
	a_dark: assert property (p_dark) else $error("output outside display");
	property p_window_out;
		@(posedge pclk) disable iff (!presetn)
		(display_control_reg[`OPC_BIT_WINDOW_ENABLE] && !in_window && !raster_on) |=> !osd_active;
	endproperty
	a_window_out: assert property (p_window_out) else $error("line outside window shown");
	property p_select_rg;
		@(posedge pclk) disable iff (!presetn)
		(display_control_reg[`OPC_BIT_CHAR_BG_SELECT] && src == opc_pkg::OPC_SRC_BG)
			|=> (palette_index[2:1] == $past(char_attribute_reg[`OPC_BIT_SLANT:`OPC_BIT_UNDERLINE])
			&& !palette_index[0]);
	endproperty
	a_select_rg: assert property (p_select_rg) else $error("attribute bg colour wrong");
	property p_ipin_plane1;
		@(posedge pclk) disable iff (!presetn)
		plane1_hit |=> (ipin_out == $past(area_plane_color_reg[`OPC_BIT_IPIN_PLANE1]));
	endproperty
	a_ipin_plane1: assert property (p_ipin_plane1) else $error("i-pin ignores plane 1");
	property p_ipin_plane2;
		@(posedge pclk) disable iff (!presetn)
		(plane2_hit && !plane1_hit)
			|=> (ipin_out == $past(area_plane_color_reg[`OPC_BIT_IPIN_PLANE2]));
	endproperty
	a_ipin_plane2: assert property (p_ipin_plane2) else $error("i-pin ignores plane 2");
	////////////////////////////////////////////////////////////////
	// line counter steps, one sync line or two in double scan
	sequence s_line_normal;
		hs_fall && !vs_fall && !double_scan && line_count_reg != '1;
	endsequence
	sequence s_line_first_half;
		hs_fall && !vs_fall && double_scan && !half_line_reg;
	endsequence
	sequence s_line_second_half;
		hs_fall && !vs_fall && double_scan && half_line_reg && line_count_reg != '1;
	endsequence
	property p_line_normal;
		@(posedge pclk) disable iff (!presetn)
		s_line_normal |=> (line_count_reg == $past(line_count_reg) + 1'b1);
	endproperty
	a_line_normal: assert property (p_line_normal) else $error("line count missed");
	property p_line_first_half;
		@(posedge pclk) disable iff (!presetn)
		s_line_first_half |=> ($stable(line_count_reg) && half_line_reg);
	endproperty
	a_line_first_half: assert property (p_line_first_half) else $error("half line counted");
	property p_line_second_half;
		@(posedge pclk) disable iff (!presetn)
		s_line_second_half |=> (line_count_reg == $past(line_count_reg) + 1'b1 && !half_line_reg);
	endproperty
	a_line_second_half: assert property (p_line_second_half) else $error("double line missed");
	property p_frame_start;
		@(posedge pclk) disable iff (!presetn)
		vs_fall |=> (line_count_reg == '0 && !half_line_reg);
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame start not cleared");
	property p_line_hold;
		@(posedge pclk) disable iff (!presetn)
		(hs_fall && !vs_fall && line_count_reg == '1) |=> (line_count_reg == '1);
	endproperty
	a_line_hold: assert property (p_line_hold) else $error("line count wrapped");
	property p_write_control;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OPC_ADDR_DISPLAY_CONTROL)
			|=> (display_control_reg == $past(pwdata[7:0]));
	endproperty
	a_write_control: assert property (p_write_control) else $error("control write lost");
endmodule

// ==== pkg/opc_params.svh ====
// How it works
// - screen background enable is raster bit 7
// - per-character background enable is attribute bit 3
// - background drawn only when both enables set
// - screen off shows planes; char off passes video
// - background colour bits 6..4 select palette
// - select bit swaps slant/underline into red/green
// - select mode leaves only even palette entries
// - display enable is control bit 0
// - window enable bit 1 limits display vertically
// - 10-bit limits in sync lines, doubled scan
// - line equal to lower limit not displayed
// - full-raster enable is raster bit 6
// - full-raster colour is raster bits 2..0
// - plane 1 wins over plane 2 on overlap
// - plane 2 on bit 5, plane 1 bit 4
// - plane colours bits 2..0 and 6..4
// - i-pin active over selected planes, by priority
`ifndef OPC_PARAMS_SVH
`define OPC_PARAMS_SVH
`define OPC_ADDR_DISPLAY_CONTROL 12'h000
`define OPC_ADDR_CHAR_ATTRIBUTE 12'h004
`define OPC_ADDR_RASTER_BG_CONTROL 12'h008
`define OPC_ADDR_BORDER_BG_COLOR 12'h00c
`define OPC_ADDR_WINDOW_UPPER 12'h010
`define OPC_ADDR_WINDOW_LOWER 12'h014
`define OPC_ADDR_AREA_PLANE_COLOR 12'h018
`define OPC_ADDR_PORT_SELECT 12'h01c
`define OPC_ADDR_STATUS 12'h020
`define OPC_BIT_DISPLAY_ENABLE 0
`define OPC_BIT_WINDOW_ENABLE 1
`define OPC_BIT_CHAR_BG_SELECT 3
`define OPC_BIT_DOUBLE_SCAN 4
`define OPC_BIT_CHAR_BG_ENABLE 3
`define OPC_BIT_SLANT 6
`define OPC_BIT_UNDERLINE 5
`define OPC_BIT_SCREEN_BG_ENABLE 7
`define OPC_BIT_FULL_RASTER 6
`define OPC_BIT_PLANE2_ON 5
`define OPC_BIT_PLANE1_ON 4
`define OPC_BIT_IPIN_PLANE1 3
`define OPC_BIT_IPIN_PLANE2 7
`define OPC_BIT_LUMA_BLANK 2
`define OPC_BIT_IPIN_DISABLE 3
`define OPC_RESET_BYTE 8'h00
`define OPC_RESET_WINDOW_UPPER 10'h001
`define OPC_RESET_WINDOW_LOWER 10'h1fe
`endif

// ==== pkg/opc_pkg.sv ====
package opc_pkg;
	typedef struct packed {
		logic [2:0] bg_color;
		logic [2:0] raster_color;
		logic [2:0] plane1_color;
		logic [2:0] plane2_color;
	} opc_colors_type;
	typedef struct packed {
		logic char_pixel;
		logic [2:0] char_color;
		logic char_area;
		logic plane1_area;
		logic plane2_area;
	} opc_pixel_type;
	typedef enum logic [2:0] {
		OPC_SRC_VIDEO = 3'b000,
		OPC_SRC_RASTER = 3'b001,
		OPC_SRC_PLANE2 = 3'b010,
		OPC_SRC_PLANE1 = 3'b011,
		OPC_SRC_BG = 3'b100,
		OPC_SRC_CHAR = 3'b101
	} opc_src_type;
endpackage

// ==== sim/opc_video_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// video path side: active-low sync pulses, both lines idle high
module opc_video_model (
	input wire logic pclk,
	output logic horizontal_sync_in,
	output logic vertical_sync_in
);
	initial begin
		horizontal_sync_in = 1'h1;
		vertical_sync_in = 1'h1;
	end
	// one line period, long enough for the input synchroniser
	task automatic hsync_pulse();
		@(posedge pclk);
		horizontal_sync_in <= 1'h0;
		repeat (4) @(posedge pclk);
		horizontal_sync_in <= 1'h1;
		repeat (8) @(posedge pclk);
	endtask
	// settling time lets the synchronised level land before return
	task automatic vsync_level(input logic v);
		@(posedge pclk);
		vertical_sync_in <= v;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// ==== sim/osd_plane_color_control_test.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module osd_plane_color_control_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic horizontal_sync_in, vertical_sync_in;
	logic osd_active, blank_out, ipin_out, ipin_enable, luma_blank_pin_select;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] palette_index;
	opc_pkg::opc_pixel_type pixel_in;
	int n_fail, n_compared;
	opc_plane_color_control opc_plane_color_control_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.horizontal_sync_in(horizontal_sync_in), .vertical_sync_in(vertical_sync_in),
		.pixel_in(pixel_in), .palette_index(palette_index), .osd_active(osd_active),
		.blank_out(blank_out), .ipin_out(ipin_out), .ipin_enable(ipin_enable),
		.luma_blank_pin_select(luma_blank_pin_select));
	opc_video_model opc_video_model_inst (.pclk(pclk), .horizontal_sync_in(horizontal_sync_in),
		.vertical_sync_in(vertical_sync_in));
	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		if (k >= 50) n_fail++;
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	// pixel bits: char_pixel, char_color, char_area, plane1_area, plane2_area
	task automatic pix(input logic [6:0] p, input logic [2:0] ei, input logic eo);
		@(posedge pclk);
		pixel_in <= opc_pkg::opc_pixel_type'(p);
		@(posedge pclk);
		#1;
		chk(palette_index, ei);
		chk(osd_active, eo);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pixel_in = '0;
		n_fail = 0;
		n_compared = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		#1;
		chk(ipin_enable, 32'h1);
		rdc(12'h010, 32'h001);
		rdc(12'h014, 32'h1fe);
		rdc(12'h008, 32'h0);
		rdc(12'h018, 32'h0);
		chk(se, 32'h0);
		apb(1'h0, 12'h040, 32'h0);
		chk(se, 32'h1);
		chk(rd, 32'h0);
		wr(12'h000, 32'h01);
		wr(12'h00c, 32'h50);
		for (int i = 0; i < 4; i++) begin
			wr(12'h008, i[1] ? 32'h80 : 32'h00);
			wr(12'h004, i[0] ? 32'h08 : 32'h00);
			pix(7'h04, (i == 3) ? 3'h5 : 3'h0, i == 3);
		end
		wr(12'h008, 32'h10);
		wr(12'h018, 32'h03);
		wr(12'h004, 32'h08);
		pix(7'h06, 3'h3, 1'h1);
		// char background off lets video through even over a plane
		wr(12'h004, 32'h00);
		pix(7'h06, 3'h0, 1'h0);
		chk(blank_out, 32'h0);
		// swapped attribute bits leave blue cleared
		wr(12'h000, 32'h09);
		wr(12'h00c, 32'h70);
		wr(12'h004, 32'h48);
		wr(12'h008, 32'h80);
		pix(7'h04, 3'h4, 1'h1);
		wr(12'h004, 32'h28);
		pix(7'h04, 3'h2, 1'h1);
		wr(12'h000, 32'h01);
		wr(12'h004, 32'h00);
		wr(12'h008, 32'h30);
		wr(12'h018, 32'h6b);
		pix(7'h03, 3'h3, 1'h1);
		chk(ipin_out, 32'h1);
		pix(7'h01, 3'h6, 1'h1);
		chk(ipin_out, 32'h0);
		// plane 1 wins the overlap, so its unselected pin stays low
		wr(12'h018, 32'he3);
		pix(7'h03, 3'h3, 1'h1);
		chk(ipin_out, 32'h0);
		pix(7'h01, 3'h6, 1'h1);
		chk(ipin_out, 32'h1);
		wr(12'h01c, 32'h0c);
		#1;
		chk({luma_blank_pin_select, ipin_enable}, 32'h2);
		wr(12'h008, 32'h45);
		pix(7'h00, 3'h5, 1'h1);
		chk(blank_out, 32'h1);
		pix(7'h7c, 3'h7, 1'h1);
		wr(12'h008, 32'h00);
		wr(12'h000, 32'h00);
		pix(7'h7c, 3'h0, 1'h0);
		chk(blank_out, 32'h0);
		// window limits changed only while vsync is low
		wr(12'h01c, 32'h00);
		opc_video_model_inst.vsync_level(1'h0);
		wr(12'h010, 32'h002);
		wr(12'h014, 32'h003);
		wr(12'h000, 32'h03);
		opc_video_model_inst.vsync_level(1'h1);
		for (int i = 0; i < 4; i++) begin
			if (i > 0) opc_video_model_inst.hsync_pulse();
			pix(7'h7c, (i == 2) ? 3'h7 : 3'h0, i == 2);
			rdc(12'h020, (i == 2) ? 32'hc02 : (32'h800 | i));
		end
		opc_video_model_inst.vsync_level(1'h0);
		wr(12'h000, 32'h13);
		opc_video_model_inst.vsync_level(1'h1);
		repeat (4) opc_video_model_inst.hsync_pulse();
		pix(7'h7c, 3'h7, 1'h1);
		rdc(12'h020, 32'hc02);
		give_verdict();
	end
	initial begin
		#100000;
		n_fail++;
		give_verdict();
	end
endmodule
